// ### rtl/sor_absent_filter.sv
`timescale 1ns/1ns
// ==========================================================
// signal-absent filter: pass-through or heavy hold-off
module sor_absent_filter #(
    parameter int HOLD_CYCLES = sor_pkg::ABSENT_HOLD_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic absent,
    input  wire logic heavy,
    output logic      flag
);
    localparam int CW = $clog2(HOLD_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(HOLD_CYCLES - 1);

    // elaboration check: a hold-off of one leaves the counter nothing to count
    if (HOLD_CYCLES < 2) begin : g_bad_hold
        $error("hold count too small");
    end

    logic [CW-1:0] count;
    wire           count_done = (count == LAST);

    // count consecutive absent cycles; any presence restarts the hold-off
    always_ff @(posedge clk) begin
        if (rst || !absent || !heavy) begin
            count <= '0;
        end else if (!count_done) begin
            count <= count + CW'(1);
        end
    end

    // heavy mode raises the flag only after the full hold-off   [RULE_07]
    always_ff @(posedge clk) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (heavy) begin
            flag <= absent && count_done;
        end else begin
            flag <= absent;
        end
    end

    // helper: run length of absence for the checks
    logic [CW:0] run;
    always_ff @(posedge clk) begin
        if (rst || !absent) begin
            run <= '0;
        end else if (run <= (CW+1)'(HOLD_CYCLES)) begin
            run <= run + (CW+1)'(1);
        end
    end

    chk_heavy_holdoff: assert property (@(posedge clk) disable iff (rst) // [RULE_07]
        $rose(flag) && $past(heavy) |-> run >= (CW+1)'(HOLD_CYCLES))
        else $error("absent flag rose before hold-off");
    chk_heavy_reaches: assert property (@(posedge clk) disable iff (rst) // [RULE_07]
        heavy && absent && count_done ##1 heavy |-> flag)
        else $error("absent flag missing after hold-off");
    cov_heavy_assert: cover property (@(posedge clk) disable iff (rst) heavy && $rose(flag));
endmodule

// ### rtl/sor_lane_override_regs.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
// Overview of operation
// [RULE_01] transmit enable bit 31 selects override fields over defaults; resets 0
// [RULE_02] emphasis field 25:22 writable, resets 0; zero means no emphasis
// [RULE_03] software read-modify-writes preserved bits to keep their value
// [RULE_04] bit 2 reads the live signal-absent flag; writes ignored
// [RULE_05] receive enable bit 14 selects override fields over defaults; resets 0
// [RULE_06] filter select 13:12 resets to 01; 00 off, 11 heavy
// [RULE_07] heavy filtering flags absence after 128 cycles without signal
// [RULE_08] equaliser level 7:5 resets 000, sets receive boost
// [RULE_09] bit 3 enables word alignment; resets to 1
// [RULE_10] bit 0 selects half-rate operation; resets to 0
// [RULE_11] defaults readback marked stale once an override is enabled
// [RULE_12] software stays off these registers while transceiver is in reset
// [RULE_13] with enable clear, effective values equal the power-up defaults; lane_ctrl is zero while reset is held
module sor_lane_override_regs #(
    parameter int HOLD_CYCLES = sor_pkg::ABSENT_HOLD_CYCLES
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic [11:0]             reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [31:0]                  reg_rdata,
    input  wire sor_pkg::sor_lane_ctrl_t power_up_default,
    input  wire logic                    signal_present_pin,
    output sor_pkg::sor_lane_ctrl_t      lane_ctrl,
    output logic                         signal_absent_flag,
    output logic                         irq
);
    // ==========================================================
    // elaboration checks
    // a hold-off below two cycles leaves the filter counter no room to count
    if (HOLD_CYCLES < 2) begin : g_bad_hold
        $error("hold-off count too small");
    end
    // the defaults readback packs two stale marks and 19 zeros above the control word
    if (2 + 19 + $bits(sor_pkg::sor_lane_ctrl_t) != 32) begin : g_bad_ctrl
        $error("lane control word does not fit the defaults readback");
    end

    // ==========================================================
    // register port
    sor_pkg::sor_req_t req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    wire hit_tx   = (req.addr == sor_pkg::OFS_TX_OVERRIDE);
    wire hit_rx   = (req.addr == sor_pkg::OFS_RX_OVERRIDE);
    wire hit_ist  = (req.addr == sor_pkg::OFS_IRQ_STATUS);
    wire hit_imsk = (req.addr == sor_pkg::OFS_IRQ_MASK);
    wire hit_def  = (req.addr == sor_pkg::OFS_DEFAULTS);
    wire wr_tx    = req.wr && hit_tx;
    wire wr_rx    = req.wr && hit_rx;
    wire wr_ist   = req.wr && hit_ist;
    wire wr_imsk  = req.wr && hit_imsk;

    // ==========================================================
    // power-up defaults: straps pass two flops, then are caught while reset is held
    sor_pkg::sor_lane_ctrl_t strap_meta;
    sor_pkg::sor_lane_ctrl_t strap_sync;
    sor_pkg::sor_lane_ctrl_t dflt;

    // straps are pins, so they are synchronised like any other pin input
    always_ff @(posedge clk) begin
        strap_meta <= power_up_default;
        strap_sync <= strap_meta;
    end

    // later strap changes are ignored: the lane must not shift under live traffic
    always_ff @(posedge clk) begin
        if (rst) begin
            dflt <= strap_sync;
        end
    end

    // ==========================================================
    // transmit override register
    logic        tx_en;
    logic [4:0]  tx_rsv;
    logic [3:0]  tx_emph;
    logic [18:0] tx_keep;

    // preserved bits simply store what software writes back   [RULE_03]
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_en   <= 1'b0;                           // [RULE_01]
            tx_rsv  <= sor_pkg::TX_RSV_RESET;
            tx_emph <= sor_pkg::TX_EMPH_RESET;         // [RULE_02]
            tx_keep <= sor_pkg::TX_KEEP_RESET;
        end else if (wr_tx) begin
            tx_en   <= req.wdata[sor_pkg::TX_EN_BIT];
            tx_rsv  <= req.wdata[sor_pkg::TX_RSV_HI:sor_pkg::TX_RSV_LO];
            tx_emph <= req.wdata[sor_pkg::TX_EMPH_HI:sor_pkg::TX_EMPH_LO];
            tx_keep <= req.wdata[sor_pkg::TX_KEEP_HI:sor_pkg::TX_KEEP_LO];
        end
    end

    // ==========================================================
    // receive override register
    logic       rx_en;
    logic [1:0] rx_filt;
    logic [3:0] rx_keep8;
    logic [2:0] rx_eq;
    logic       rx_keep4;
    logic       rx_align;
    logic [1:0] rx_keep1;
    logic       rx_half;

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_en    <= 1'b0;                          // [RULE_05]
            rx_filt  <= sor_pkg::RX_FILT_RESET;        // [RULE_06]
            rx_keep8 <= sor_pkg::RX_KEEP8_RESET;
            rx_eq    <= sor_pkg::RX_EQ_RESET;          // [RULE_08]
            rx_keep4 <= sor_pkg::RX_KEEP4_RESET;
            rx_align <= sor_pkg::RX_ALIGN_RESET;       // [RULE_09]
            rx_keep1 <= sor_pkg::RX_KEEP1_RESET;
            rx_half  <= sor_pkg::RX_HALF_RESET;        // [RULE_10]
        end else if (wr_rx) begin
            rx_en    <= req.wdata[sor_pkg::RX_EN_BIT];
            rx_filt  <= req.wdata[sor_pkg::RX_FILT_HI:sor_pkg::RX_FILT_LO];
            rx_keep8 <= req.wdata[sor_pkg::RX_KEEP8_HI:sor_pkg::RX_KEEP8_LO];
            rx_eq    <= req.wdata[sor_pkg::RX_EQ_HI:sor_pkg::RX_EQ_LO];
            rx_keep4 <= req.wdata[sor_pkg::RX_KEEP4_BIT];
            rx_align <= req.wdata[sor_pkg::RX_ALIGN_BIT];
            rx_keep1 <= req.wdata[sor_pkg::RX_KEEP1_HI:sor_pkg::RX_KEEP1_LO];
            rx_half  <= req.wdata[sor_pkg::RX_HALF_BIT];
        end
    end

    // ==========================================================
    // effective lane controls: override fields only while enabled
    sor_pkg::sor_lane_ctrl_t next_lane_ctrl;
    assign next_lane_ctrl.tx_emphasis = tx_en ? tx_emph : dflt.tx_emphasis;     // [RULE_01] [RULE_13]
    assign next_lane_ctrl.signal_absent_filter_select =
        rx_en ? rx_filt : dflt.signal_absent_filter_select;                      // [RULE_05] [RULE_13]
    assign next_lane_ctrl.receive_equalizer_level =
        rx_en ? rx_eq : dflt.receive_equalizer_level;                            // [RULE_08]
    assign next_lane_ctrl.align_en  = rx_en ? rx_align : dflt.align_en;         // [RULE_09]
    assign next_lane_ctrl.half_rate = rx_en ? rx_half : dflt.half_rate;         // [RULE_10]

    // registered so the analogue controls never see decode glitches
    // zero while reset is held; the defaults appear one edge after release
    always_ff @(posedge clk) begin
        if (rst) begin
            lane_ctrl <= '0;
        end else begin
            lane_ctrl <= next_lane_ctrl;
        end
    end

    // ==========================================================
    // signal-present pin synchroniser and filter
    logic present_meta;
    logic present_sync;
    always_ff @(posedge clk) begin
        if (rst) begin
            present_meta <= 1'b1;
            present_sync <= 1'b1;
        end else begin
            present_meta <= signal_present_pin;
            present_sync <= present_meta;
        end
    end

    // the filter sees the registered select, so a select change costs one cycle
    // reserved filter codes behave as filtering off
    wire heavy_sel = (lane_ctrl.signal_absent_filter_select == sor_pkg::FILT_HEAVY); // [RULE_06]

    sor_absent_filter #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_filter (
        .clk    (clk),
        .rst    (rst),
        .absent (!present_sync),
        .heavy  (heavy_sel),
        .flag   (signal_absent_flag)
    );

    // ==========================================================
    // interrupts: edges of the absent flag, write one to clear
    logic                      absent_q;
    logic [sor_pkg::IRQ_BITS-1:0] irq_status;
    logic [sor_pkg::IRQ_BITS-1:0] irq_mask;
    logic [sor_pkg::IRQ_BITS-1:0] irq_events;
    logic [sor_pkg::IRQ_BITS-1:0] next_irq_status;

    assign irq_events[sor_pkg::IRQ_ABSENT_SET_BIT] = signal_absent_flag && !absent_q;
    assign irq_events[sor_pkg::IRQ_ABSENT_CLR_BIT] = !signal_absent_flag && absent_q;
    // mask write and status update share one edge, so irq never lags a write
    // a new event wins over a simultaneous clear
    assign next_irq_status = (irq_status & ~(wr_ist ? req.wdata[sor_pkg::IRQ_BITS-1:0] : '0)) | irq_events;

    always_ff @(posedge clk) begin
        if (rst) begin
            absent_q   <= 1'b0;
            irq_status <= '0;
            irq_mask   <= '0;
            irq        <= 1'b0;
        end else begin
            absent_q   <= signal_absent_flag;
            irq_status <= next_irq_status;
            irq_mask   <= wr_imsk ? req.wdata[sor_pkg::IRQ_BITS-1:0] : irq_mask;
            irq        <= |(next_irq_status & (wr_imsk ? req.wdata[sor_pkg::IRQ_BITS-1:0] : irq_mask));
        end
    end

    // ==========================================================
    // read data: valid only in the cycle after the read strobe
    // reads have no side effects, so back-to-back reads of one register are safe
    logic [31:0] tx_word;
    logic [31:0] rx_word;
    logic [31:0] def_word;
    logic [31:0] next_rdata;

    assign tx_word = {tx_en, tx_rsv, tx_emph, tx_keep, signal_absent_flag, 2'h0};  // [RULE_04]
    assign rx_word = {17'h00000, rx_en, rx_filt, rx_keep8, rx_eq, rx_keep4, rx_align, rx_keep1, rx_half};
    // stale marks tell software the defaults no longer describe the lane
    assign def_word = {tx_en, rx_en, 19'h00000, dflt};                            // [RULE_11]

    assign next_rdata = !req.rd   ? 32'h0000_0000 :
                        hit_tx    ? tx_word :
                        hit_rx    ? rx_word :
                        hit_ist   ? {30'h0000_0000, irq_status} :
                        hit_imsk  ? {30'h0000_0000, irq_mask} :
                        hit_def   ? def_word :
                                    32'h0000_0000;

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // ==========================================================
    // checks
    // the edge that releases reset still loads zero lanes, so it starts no attempt
    chk_tx_default_used: assert property (@(posedge clk) disable iff (rst) // [RULE_13]
        !rst && !tx_en ##1 1'b1 |-> lane_ctrl.tx_emphasis == $past(dflt.tx_emphasis))
        else $error("transmit default not applied");
    chk_tx_override_used: assert property (@(posedge clk) disable iff (rst) // [RULE_01]
        wr_tx && req.wdata[sor_pkg::TX_EN_BIT] ##2 1'b1
        |-> lane_ctrl.tx_emphasis == $past(req.wdata[sor_pkg::TX_EMPH_HI:sor_pkg::TX_EMPH_LO], 2))
        else $error("transmit override not applied");
    chk_emph_reset_zero: assert property (@(posedge clk) // [RULE_02]
        $fell(rst) |-> tx_emph == sor_pkg::TX_EMPH_RESET && !tx_en)
        else $error("emphasis not zero after reset");
    chk_absent_readback: assert property (@(posedge clk) disable iff (rst) // [RULE_04]
        req.rd && hit_tx |=> reg_rdata[sor_pkg::TX_ABSENT_BIT] == $past(signal_absent_flag))
        else $error("absent bit readback wrong");
    chk_rx_override_used: assert property (@(posedge clk) disable iff (rst) // [RULE_05]
        wr_rx && req.wdata[sor_pkg::RX_EN_BIT] ##2 1'b1
        |-> lane_ctrl.receive_equalizer_level == $past(req.wdata[sor_pkg::RX_EQ_HI:sor_pkg::RX_EQ_LO], 2))
        else $error("receive override not applied");
    chk_rx_reset_vals: assert property (@(posedge clk) // [RULE_06]
        $fell(rst) |-> rx_filt == sor_pkg::RX_FILT_RESET && rx_eq == sor_pkg::RX_EQ_RESET
            && rx_align == sor_pkg::RX_ALIGN_RESET && rx_half == sor_pkg::RX_HALF_RESET && !rx_en)
        else $error("receive reset values wrong");
    chk_align_follows: assert property (@(posedge clk) disable iff (rst) // [RULE_09]
        rx_en ##1 1'b1 |-> lane_ctrl.align_en == $past(rx_align))
        else $error("alignment enable not applied");
    chk_half_default: assert property (@(posedge clk) disable iff (rst) // [RULE_10]
        !rst && !rx_en ##1 1'b1 |-> lane_ctrl.half_rate == $past(dflt.half_rate))
        else $error("half-rate default not applied");
    chk_stale_marks: assert property (@(posedge clk) disable iff (rst) // [RULE_11]
        req.rd && hit_def |=> reg_rdata[sor_pkg::DEF_TX_STALE_BIT] == $past(tx_en)
                           && reg_rdata[sor_pkg::DEF_RX_STALE_BIT] == $past(rx_en))
        else $error("stale marks wrong");
    chk_irq_sticky: assert property (@(posedge clk) disable iff (rst)
        irq_events[sor_pkg::IRQ_ABSENT_SET_BIT] |=> irq_status[sor_pkg::IRQ_ABSENT_SET_BIT])
        else $error("absent event lost");
    chk_irq_cleared: assert property (@(posedge clk) disable iff (rst)
        wr_ist && req.wdata[sor_pkg::IRQ_ABSENT_SET_BIT] && !irq_events[sor_pkg::IRQ_ABSENT_SET_BIT]
        |=> !irq_status[sor_pkg::IRQ_ABSENT_SET_BIT])
        else $error("status bit not cleared by write");

    // receive defaults while the receive override is off; unfiltered flag while heavy filtering is not selected
    chk_filter_default: assert property (@(posedge clk) disable iff (rst) // [RULE_13]
        !rst && !rx_en ##1 1'b1
        |-> lane_ctrl.signal_absent_filter_select == $past(dflt.signal_absent_filter_select))
        else $error("filter default not applied");
    chk_eq_default: assert property (@(posedge clk) disable iff (rst) // [RULE_13]
        !rst && !rx_en ##1 1'b1 |-> lane_ctrl.receive_equalizer_level == $past(dflt.receive_equalizer_level))
        else $error("equaliser default not applied");
    chk_filter_off: assert property (@(posedge clk) disable iff (rst) // [RULE_06]
        !heavy_sel |=> signal_absent_flag == $past(!present_sync))
        else $error("unfiltered flag does not follow the pin");

    // readback layout: unbacked bits read zero, read data lasts one cycle
    chk_rdata_idle: assert property (@(posedge clk) disable iff (rst)
        !req.rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data not cleared after the read cycle");
    chk_tx_low_zero: assert property (@(posedge clk) disable iff (rst)
        req.rd && hit_tx |=> reg_rdata[1:0] == 2'h0)
        else $error("transmit reserved bits not zero");
    chk_rx_high_zero: assert property (@(posedge clk) disable iff (rst)
        req.rd && hit_rx |=> reg_rdata[31:sor_pkg::RX_EN_BIT+1] == 17'h00000)
        else $error("receive upper bits not zero");

    cov_tx_override: cover property (@(posedge clk) disable iff (rst) wr_tx && req.wdata[sor_pkg::TX_EN_BIT]);
    cov_rx_override: cover property (@(posedge clk) disable iff (rst) wr_rx && req.wdata[sor_pkg::RX_EN_BIT]);
    cov_irq_raised:  cover property (@(posedge clk) disable iff (rst) $rose(irq));
endmodule

// ### rtl/sor_pkg.sv
// ==========================================================
// shared constants and types for the lane override registers
package sor_pkg;

    // register byte offsets
    localparam logic [11:0] OFS_TX_OVERRIDE = 12'h004;
    localparam logic [11:0] OFS_RX_OVERRIDE = 12'h008;
    localparam logic [11:0] OFS_IRQ_STATUS  = 12'h040;
    localparam logic [11:0] OFS_IRQ_MASK    = 12'h044;
    localparam logic [11:0] OFS_DEFAULTS    = 12'h048;

    // transmit override register fields
    localparam int TX_EN_BIT      = 31;
    localparam int TX_RSV_HI      = 30;
    localparam int TX_RSV_LO      = 26;
    localparam int TX_EMPH_HI     = 25;
    localparam int TX_EMPH_LO     = 22;
    localparam int TX_KEEP_HI     = 21;
    localparam int TX_KEEP_LO     = 3;
    localparam int TX_ABSENT_BIT  = 2;

    // receive override register fields
    localparam int RX_EN_BIT      = 14;
    localparam int RX_FILT_HI     = 13;
    localparam int RX_FILT_LO     = 12;
    localparam int RX_KEEP8_HI    = 11;
    localparam int RX_KEEP8_LO    = 8;
    localparam int RX_EQ_HI       = 7;
    localparam int RX_EQ_LO       = 5;
    localparam int RX_KEEP4_BIT   = 4;
    localparam int RX_ALIGN_BIT   = 3;
    localparam int RX_KEEP1_HI    = 2;
    localparam int RX_KEEP1_LO    = 1;
    localparam int RX_HALF_BIT    = 0;

    // defaults readback: stale flags
    localparam int DEF_TX_STALE_BIT = 31;
    localparam int DEF_RX_STALE_BIT = 30;

    // interrupt status bits
    localparam int IRQ_ABSENT_SET_BIT = 0;
    localparam int IRQ_ABSENT_CLR_BIT = 1;
    localparam int IRQ_BITS           = 2;

    // reset values
    localparam logic [4:0]  TX_RSV_RESET   = 5'h00;
    localparam logic [3:0]  TX_EMPH_RESET  = 4'h0;
    localparam logic [18:0] TX_KEEP_RESET  = 19'h00000;
    localparam logic [1:0]  RX_FILT_RESET  = 2'h1;
    localparam logic [3:0]  RX_KEEP8_RESET = 4'h0;
    localparam logic [2:0]  RX_EQ_RESET    = 3'h0;
    localparam logic        RX_KEEP4_RESET = 1'h1;
    localparam logic        RX_ALIGN_RESET = 1'h1;
    localparam logic [1:0]  RX_KEEP1_RESET = 2'h3;
    localparam logic        RX_HALF_RESET  = 1'h0;

    // filter encodings
    localparam logic [1:0] FILT_OFF   = 2'h0;
    localparam logic [1:0] FILT_HEAVY = 2'h3;

    // heavy filter hold-off, in clock cycles
    localparam int ABSENT_HOLD_CYCLES = 128;

    // lane control values handed to the transceiver
    typedef struct packed {
        logic [3:0] tx_emphasis;
        logic [1:0] signal_absent_filter_select;
        logic [2:0] receive_equalizer_level;
        logic       align_en;
        logic       half_rate;
    } sor_lane_ctrl_t;

    // register port request
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } sor_req_t;

endpackage

// ### verif/sor_lane_override_regs_bench.sv
`timescale 1ns/1ns
// ==========================================================
// self-checking bench for the lane override registers
module sor_lane_override_regs_bench;
    localparam int HOLD = 8;  // short hold-off keeps the filter run brief

    logic                    clk;
    logic                    rst;
    logic [11:0]             reg_addr;
    logic [31:0]             reg_wdata;
    logic                    reg_wr;
    logic                    reg_rd;
    logic [31:0]             reg_rdata;
    sor_pkg::sor_lane_ctrl_t power_up_default;
    logic                    signal_present_pin;
    sor_pkg::sor_lane_ctrl_t lane_ctrl;
    logic                    signal_absent_flag;
    logic                    irq;
    int                      n_errors;
    int                      n_checks;
    logic [31:0]             rd;
    sor_pkg::sor_lane_ctrl_t dflt;

    sor_lane_override_regs #(.HOLD_CYCLES(HOLD)) i_dut (
        .clk                (clk),
        .rst                (rst),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_wr             (reg_wr),
        .reg_rd             (reg_rd),
        .reg_rdata          (reg_rdata),
        .power_up_default   (power_up_default),
        .signal_present_pin (signal_present_pin),
        .lane_ctrl          (lane_ctrl),
        .signal_absent_flag (signal_absent_flag),
        .irq                (irq)
    );

    // ==========================================================
    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========================================================
    // bus and compare tasks
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_ctrl(input sor_pkg::sor_lane_ctrl_t exp);
        repeat (2) @(posedge clk);  // lane edge after the write, then one spare edge
        #1 chk_word(32'(lane_ctrl), 32'(exp));
    endtask

    function automatic sor_pkg::sor_lane_ctrl_t mk(logic [3:0] e, logic [1:0] f, logic [2:0] q, logic a, logic h);
        mk = {e, f, q, a, h};
    endfunction

    // ==========================================================
    // scenarios
    task automatic t_reset();
        rd_reg(sor_pkg::OFS_TX_OVERRIDE, rd);
        chk_word(rd, 32'h0000_0000);
        rd_reg(sor_pkg::OFS_RX_OVERRIDE, rd);
        chk_word(rd, 32'h0000_101e);
        chk_ctrl(dflt);
        $display("test reset done");
    endtask

    task automatic t_tx();
        sor_pkg::sor_lane_ctrl_t exp;
        exp = dflt;
        wr_reg(sor_pkg::OFS_TX_OVERRIDE, 32'hffff_ffff);
        exp.tx_emphasis = 4'hf;
        chk_ctrl(exp);
        rd_reg(sor_pkg::OFS_TX_OVERRIDE, rd);
        chk_word(rd, 32'hffff_fff8);
        rd_reg(sor_pkg::OFS_TX_OVERRIDE, rd);
        wr_reg(sor_pkg::OFS_TX_OVERRIDE, (rd & 32'hfc3f_ffff));
        exp.tx_emphasis = 4'h0;
        chk_ctrl(exp);
        rd_reg(sor_pkg::OFS_TX_OVERRIDE, rd);
        wr_reg(sor_pkg::OFS_TX_OVERRIDE, (rd & 32'h7fff_fffb) | 32'h03c0_0000);
        chk_ctrl(dflt);
        $display("test tx override done");
    endtask

    task automatic t_rx();
        wr_reg(sor_pkg::OFS_RX_OVERRIDE, 32'hffff_4fb7);
        chk_ctrl(mk(dflt.tx_emphasis, 2'h0, 3'h5, 1'b0, 1'b1));
        rd_reg(sor_pkg::OFS_RX_OVERRIDE, rd);
        chk_word(rd, 32'h0000_4fb7);
        rd_reg(sor_pkg::OFS_DEFAULTS, rd);
        chk_word(rd, {2'h1, 19'h00000, dflt});
        wr_reg(sor_pkg::OFS_RX_OVERRIDE, 32'h0000_0fbf);
        chk_ctrl(dflt);
        $display("test rx override done");
    endtask

    task automatic t_unmapped();
        wr_reg(12'h00c, 32'hffff_ffff);
        rd_reg(12'h00c, rd);
        chk_word(rd, 32'h0000_0000);
        rd_reg(12'h000, rd);
        chk_word(rd, 32'h0000_0000);
        $display("test unmapped done");
    endtask

    // filter off: flag follows the pin after the sync and filter flops
    task automatic t_filter_off();
        @(posedge clk);
        signal_present_pin <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk_word(32'(signal_absent_flag), 32'h0);
        @(posedge clk);
        #1 chk_word(32'(signal_absent_flag), 32'h1);
        rd_reg(sor_pkg::OFS_TX_OVERRIDE, rd);
        chk_word(rd & 32'h0000_0004, 32'h0000_0004);
        chk_word(32'(irq), 32'h0);
        @(posedge clk);
        signal_present_pin <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk_word(32'(signal_absent_flag), 32'h0);
        $display("test filter off done");
    endtask

    task automatic t_heavy();
        int n;
        wr_reg(sor_pkg::OFS_RX_OVERRIDE, 32'h0000_701e);
        repeat (4) @(posedge clk);
        signal_present_pin <= 1'b0;
        n = 0;
        while (n < 60) begin
            @(posedge clk);
            n++;
            #1;
            if (signal_absent_flag === 1'b1) break;
        end
        // a timeout is counted here and reaches the verdict through the normal path
        if (n >= 60) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, n, HOLD + 2);
        end
        // two sync flops come ahead of the hold-off; the check allows four cycles early and five late
        chk_word(32'(n >= HOLD - 2 && n <= HOLD + 7), 32'h1);
        @(posedge clk);
        signal_present_pin <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk_word(32'(signal_absent_flag), 32'h0);
        wr_reg(sor_pkg::OFS_RX_OVERRIDE, 32'h0000_101e);
        $display("test heavy filter done");
    endtask

    // sticky status, masking, write-one-to-clear
    task automatic t_irq();
        rd_reg(sor_pkg::OFS_IRQ_STATUS, rd);
        chk_word(rd, 32'h0000_0003);
        wr_reg(sor_pkg::OFS_IRQ_MASK, 32'h0000_0001);
        repeat (2) @(posedge clk);
        #1 chk_word(32'(irq), 32'h1);
        wr_reg(sor_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
        repeat (2) @(posedge clk);
        #1 chk_word(32'(irq), 32'h0);
        rd_reg(sor_pkg::OFS_IRQ_STATUS, rd);
        chk_word(rd, 32'h0000_0002);
        wr_reg(sor_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
        rd_reg(sor_pkg::OFS_IRQ_STATUS, rd);
        chk_word(rd, 32'h0000_0000);
        $display("test interrupt done");
    endtask

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        n_errors           = 0;
        n_checks           = 0;
        rst                = 1'b1;
        reg_addr           = 12'h000;
        reg_wdata          = 32'h0000_0000;
        reg_wr             = 1'b0;
        reg_rd             = 1'b0;
        signal_present_pin = 1'b1;
        dflt               = mk(4'hb, 2'h0, 3'h2, 1'b1, 1'b0);  // filter off by strap
        power_up_default   = dflt;
        // no register access while reset is held
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_tx();
        t_rx();
        t_unmapped();
        t_filter_off();
        t_heavy();
        t_irq();
        end_sim();
    end
endmodule
